// ==== design/ist_regs.svh ====
// Register offsets, field positions, reset values and counts of the slave
`ifndef IST_REGS_SVH
`define IST_REGS_SVH

// Register offsets on the plain register port
`define IST_OFS_DATA     8'h00
`define IST_OFS_OWN      8'h01
`define IST_OFS_MODE     8'h02
`define IST_OFS_STAT     8'h03
`define IST_OFS_TOC      8'h04
`define IST_OFS_IRQC     8'h05

// interface_mode_control fields
`define IST_MODE_FLD_HI  7
`define IST_MODE_FLD_LO  5
`define IST_MODE_ON_BIT  1
`define IST_MODE_I2C     3'h6

// bus_status_control fields
`define IST_ST_DONE      7
`define IST_ST_MATCH     6
`define IST_ST_BUSY      5
`define IST_ST_TX        4
`define IST_ST_ACKTX     3
`define IST_ST_RD        2
`define IST_ST_WAKE      1
`define IST_ST_ACKRX     0

// bus_timeout_control fields
`define IST_TO_EN_BIT    7
`define IST_TO_FLAG_BIT  6
`define IST_TO_SEL_HI    5

// Reset values
`define IST_RST_DATA     8'h00
`define IST_RST_OWN      8'h00
`define IST_RST_MODE     8'hE0
`define IST_RST_STAT     8'h81
`define IST_RST_TOC      8'h00
`define IST_RST_IRQC     8'h00

// Low-speed clock periods in one time-out unit
`define IST_TO_PRESCALE  32

`endif

// ==== design/ist_pkg.sv ====
// Types shared by the slave design
package ist_pkg;

  // Bus-side sequencer states
  typedef enum logic [2:0] {
    IST_IDLE,
    IST_ADDR,
    IST_ADDR_ACK,
    IST_WAIT_SW,
    IST_DATA,
    IST_ACK_BIT,
    IST_IGNORE
  } ist_state_t;

endpackage : ist_pkg

// ==== design/ist_sync.sv ====
// Two-flop synchroniser for asynchronous input pins
`timescale 1ns/1ps
module ist_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  // Asynchronous inputs and synchronised outputs
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("ist_sync: WIDTH must be at least 1");
    end
  end

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule : ist_sync

// ==== design/ist_i2c_slave.sv ====
// I2C slave with address match, byte handling, clock stretch and time-out
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ist_regs.svh"
module ist_i2c_slave
  import ist_pkg::*;
#(
  parameter int TO_PRESCALE = `IST_TO_PRESCALE
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // I2C pins, open drain
  input  wire logic       scl_in,
  output logic            scl_drv_out,
  output logic            scl_oe_out,
  input  wire logic       sda_in,
  output logic            sda_drv_out,
  output logic            sda_oe_out,
  // Low-speed clock for the time-out
  input  wire logic       low_speed_clock_in,
  // Interrupt request pulse
  output logic            serial_irq_out
);

  initial begin
    if (TO_PRESCALE < 2 || TO_PRESCALE > 256) begin
      $error("ist_i2c_slave: TO_PRESCALE must be 2..256");
    end
  end

  // Synchronised pins and their delayed copies for edge detection
  logic [2:0] pins_sync;
  logic       scl_s;
  logic       sda_s;
  logic       ls_s;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       ls_d_reg;

  ist_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .async_in   ({low_speed_clock_in, sda_in, scl_in}),
    .sync_out   (pins_sync)
  );

  assign scl_s = pins_sync[0];
  assign sda_s = pins_sync[1];
  assign ls_s  = pins_sync[2];

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      ls_d_reg  <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      ls_d_reg  <= ls_s;
    end
  end

  // Bus events
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire ls_rise  = ls_s & ~ls_d_reg;
  wire start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Registers
  ist_state_t state_reg, state_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [7:0] buf_reg, buf_next;
  logic [7:0] own_reg;
  logic [7:0] mode_reg;
  logic       hcf_reg, hcf_next;
  logic       address_match_flag_reg, address_match_flag_next;
  logic       hbb_reg, hbb_next;
  logic       htx_reg, htx_next;
  logic       ack_to_send_reg, ack_to_send_next;
  logic       srw_reg, srw_next;
  logic       wake_reg, wake_next;
  logic       ack_received_flag_reg, ack_received_flag_next;
  logic       hit_reg, hit_next;
  logic       sda_oe_next;
  logic       scl_oe_next;
  logic       to_en_reg, to_en_next;
  logic       to_flag_reg, to_flag_next;
  logic [5:0] to_sel_reg;
  logic       to_run_reg, to_run_next;
  logic [7:0] pre_cnt_reg, pre_cnt_next;
  logic [6:0] unit_cnt_reg, unit_cnt_next;
  logic       irq_en_reg;
  logic       ev_match;
  logic       ev_byte;

  // Address decode
  wire sel_data = (reg_addr_in == `IST_OFS_DATA);
  wire sel_own  = (reg_addr_in == `IST_OFS_OWN);
  wire sel_mode = (reg_addr_in == `IST_OFS_MODE);
  wire sel_stat = (reg_addr_in == `IST_OFS_STAT);
  wire sel_toc  = (reg_addr_in == `IST_OFS_TOC);
  wire sel_irqc = (reg_addr_in == `IST_OFS_IRQC);
  wire wr_data  = reg_wr_in & sel_data;
  wire wr_stat  = reg_wr_in & sel_stat;
  wire wr_toc   = reg_wr_in & sel_toc;
  wire buf_touch = wr_data | (reg_rd_in & sel_data);

  wire [7:0] stat_val = {hcf_reg, address_match_flag_reg, hbb_reg, htx_reg,
                         ack_to_send_reg, srw_reg, wake_reg, ack_received_flag_reg};
  wire [7:0] toc_val  = {to_en_reg, to_flag_reg, to_sel_reg};
  wire [2:0] mode_fld = mode_reg[`IST_MODE_FLD_HI:`IST_MODE_FLD_LO];
  wire       enabled  = mode_reg[`IST_MODE_ON_BIT] & (mode_fld == `IST_MODE_I2C);

  // Time-out: ticks every TO_PRESCALE low-speed rising edges, fires at sel+1 units
  wire pre_wrap    = ls_rise & (pre_cnt_reg == 8'(TO_PRESCALE - 1));
  wire timeout_hit = to_run_reg & to_en_reg & pre_wrap
                     & (unit_cnt_reg == {1'b0, to_sel_reg});

  // Transmit byte as loaded in this cycle, used when leaving the stretch
  wire [7:0] tx_load = wr_data ? reg_wdata_in : buf_reg;

  // Read data mux; unmapped offsets read zero
  wire [7:0] rd_mux = sel_data ? buf_reg :
                      sel_own  ? own_reg :
                      sel_mode ? mode_reg :
                      sel_stat ? stat_val :
                      sel_toc  ? toc_val :
                      sel_irqc ? {7'h00, irq_en_reg} : 8'h00;

  // Bus sequencer and status flags
  always_comb begin
    state_next  = state_reg;
    bitcnt_next = bitcnt_reg;
    buf_next    = wr_data ? reg_wdata_in : buf_reg;
    hcf_next    = hcf_reg;
    address_match_flag_next   = address_match_flag_reg;
    hbb_next    = hbb_reg;
    htx_next    = wr_stat ? reg_wdata_in[`IST_ST_TX] : htx_reg;
    ack_to_send_next   = wr_stat ? reg_wdata_in[`IST_ST_ACKTX] : ack_to_send_reg;
    srw_next    = wr_stat ? reg_wdata_in[`IST_ST_RD] : srw_reg;
    wake_next   = wr_stat ? reg_wdata_in[`IST_ST_WAKE] : wake_reg;
    ack_received_flag_next   = ack_received_flag_reg;
    hit_next    = hit_reg;
    sda_oe_next = sda_oe_out;
    scl_oe_next = scl_oe_out;
    ev_match    = 1'b0;
    ev_byte     = 1'b0;
    if (timeout_hit) begin
      // Status register back to its reset image, bus logic idle
      state_next  = IST_IDLE;
      {hcf_next, address_match_flag_next, hbb_next, htx_next,
       ack_to_send_next, srw_next, wake_next, ack_received_flag_next} = `IST_RST_STAT;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
    end else if (!enabled) begin
      // Control bits kept, flags to defaults
      state_next  = IST_IDLE;
      hcf_next    = 1'(`IST_RST_STAT >> `IST_ST_DONE);
      address_match_flag_next   = 1'b0;
      hbb_next    = 1'b0;
      srw_next    = 1'b0;
      ack_received_flag_next   = 1'b1;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
    end else if (stop_ev) begin
      state_next  = IST_IDLE;
      hbb_next    = 1'b0;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
    end else if (start_ev) begin
      state_next  = IST_ADDR;
      bitcnt_next = 4'h0;
      hbb_next    = 1'b1;
      address_match_flag_next   = 1'b0;
      hit_next    = 1'b0;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
    end else begin
      case (state_reg)
        IST_ADDR: begin
          if (scl_rise) begin
            buf_next    = {buf_reg[6:0], sda_s};
            bitcnt_next = bitcnt_reg + 4'h1;
            if (bitcnt_reg == 4'h7) begin
              hit_next = (buf_reg[6:0] == own_reg[7:1]);
              if (buf_reg[6:0] == own_reg[7:1]) begin
                srw_next = sda_s;
              end
            end
          end else if (scl_fall && bitcnt_reg == 4'h8) begin
            if (hit_reg) begin
              sda_oe_next = 1'b1;
              address_match_flag_next   = 1'b1;
              ev_match    = 1'b1;
              state_next  = IST_ADDR_ACK;
            end else begin
              state_next  = IST_IGNORE;
            end
          end
        end
        IST_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_next = 1'b0;
            scl_oe_next = 1'b1;
            state_next  = IST_WAIT_SW;
          end
        end
        IST_WAIT_SW: begin
          if (buf_touch) begin
            scl_oe_next = 1'b0;
            bitcnt_next = 4'h0;
            hcf_next    = 1'b0;
            state_next  = IST_DATA;
            if (htx_reg) begin
              sda_oe_next = ~tx_load[7];
            end
          end
        end
        IST_DATA: begin
          if (scl_rise) begin
            bitcnt_next = bitcnt_reg + 4'h1;
            if (!htx_reg) begin
              buf_next = {buf_reg[6:0], sda_s};
            end
          end else if (scl_fall && bitcnt_reg == 4'h8) begin
            hcf_next    = 1'b1;
            ev_byte     = 1'b1;
            state_next  = IST_ACK_BIT;
            sda_oe_next = htx_reg ? 1'b0 : ~ack_to_send_reg;
          end else if (scl_fall && htx_reg) begin
            buf_next    = {buf_reg[6:0], 1'b0};
            sda_oe_next = ~buf_reg[6];
          end
        end
        IST_ACK_BIT: begin
          if (scl_rise && htx_reg) begin
            ack_received_flag_next = sda_s;
          end else if (scl_fall) begin
            sda_oe_next = 1'b0;
            if (htx_reg && ack_received_flag_reg) begin
              state_next = IST_IGNORE;
            end else begin
              scl_oe_next = 1'b1;
              state_next  = IST_WAIT_SW;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Time-out counter control
  always_comb begin
    to_run_next   = to_run_reg;
    pre_cnt_next  = pre_cnt_reg;
    unit_cnt_next = unit_cnt_reg;
    to_en_next    = wr_toc ? reg_wdata_in[`IST_TO_EN_BIT] : to_en_reg;
    // Set wins over a write of zero in the same cycle
    to_flag_next  = timeout_hit |
                    (to_flag_reg &
                     ~(wr_toc & ~reg_wdata_in[`IST_TO_FLAG_BIT]));
    if (timeout_hit) begin
      to_run_next = 1'b0;
      to_en_next  = 1'b0;
    end else if (stop_ev || !enabled) begin
      to_run_next = 1'b0;
    end else if (ev_match) begin
      to_run_next = 1'b1;
    end
    if (scl_fall || ev_match || !to_run_reg) begin
      pre_cnt_next  = 8'h00;
      unit_cnt_next = 7'h00;
    end else if (ls_rise) begin
      pre_cnt_next = pre_wrap ? 8'h00 : pre_cnt_reg + 8'h01;
      if (pre_wrap) begin
        unit_cnt_next = unit_cnt_reg + 7'h01;
      end
    end
  end

  // Sequencer and flag state
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg  <= IST_IDLE;
      bitcnt_reg <= 4'h0;
      buf_reg    <= `IST_RST_DATA;
      {hcf_reg, address_match_flag_reg, hbb_reg, htx_reg,
       ack_to_send_reg, srw_reg, wake_reg, ack_received_flag_reg} <= `IST_RST_STAT;
      hit_reg    <= 1'b0;
      sda_oe_out <= 1'b0;
      scl_oe_out <= 1'b0;
    end else begin
      state_reg  <= state_next;
      bitcnt_reg <= bitcnt_next;
      buf_reg    <= buf_next;
      {hcf_reg, address_match_flag_reg, hbb_reg, htx_reg,
       ack_to_send_reg, srw_reg, wake_reg, ack_received_flag_reg} <=
        {hcf_next, address_match_flag_next, hbb_next, htx_next,
         ack_to_send_next, srw_next, wake_next, ack_received_flag_next};
      hit_reg    <= hit_next;
      sda_oe_out <= sda_oe_next;
      scl_oe_out <= scl_oe_next;
    end
  end

  // Time-out state
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      to_en_reg    <= 1'(`IST_RST_TOC >> `IST_TO_EN_BIT);
      to_flag_reg  <= 1'b0;
      to_sel_reg   <= 6'h00;
      to_run_reg   <= 1'b0;
      pre_cnt_reg  <= 8'h00;
      unit_cnt_reg <= 7'h00;
    end else begin
      to_en_reg    <= to_en_next;
      to_flag_reg  <= to_flag_next;
      to_sel_reg   <= wr_toc ? reg_wdata_in[`IST_TO_SEL_HI:0] : to_sel_reg;
      to_run_reg   <= to_run_next;
      pre_cnt_reg  <= pre_cnt_next;
      unit_cnt_reg <= unit_cnt_next;
    end
  end

  // Plain configuration registers; time-out leaves them untouched
  // Debounce bits are stored only: the two-flop sampler is the filter
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      own_reg    <= `IST_RST_OWN;
      mode_reg   <= `IST_RST_MODE;
      irq_en_reg <= 1'b0;
    end else begin
      if (reg_wr_in && sel_own) begin
        own_reg <= reg_wdata_in;
      end
      if (reg_wr_in && sel_mode) begin
        mode_reg <= reg_wdata_in & 8'hEF; // Bit 4 reads zero
      end
      if (reg_wr_in && sel_irqc) begin
        irq_en_reg <= reg_wdata_in[0];
      end
    end
  end

  // Read data and interrupt pulse, both registered
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out  <= 8'h00;
      serial_irq_out <= 1'b0;
      scl_drv_out    <= 1'b0;
      sda_drv_out    <= 1'b0;
    end else begin
      reg_rdata_out  <= reg_rd_in ? rd_mux : 8'h00;
      serial_irq_out <= irq_en_reg & (ev_match | ev_byte | timeout_hit);
      scl_drv_out    <= 1'b0; // Open drain: only ever pulls low
      sda_drv_out    <= 1'b0;
    end
  end

endmodule : ist_i2c_slave

// ==== verification/ist_i2c_slave_sva.sv ====
// Port-level checker for the I2C slave
`timescale 1ns/1ps
module ist_i2c_slave_sva (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Pins and interrupt
  input wire logic       scl_in,
  input wire logic       scl_drv_out,
  input wire logic       scl_oe_out,
  input wire logic       sda_drv_out,
  input wire logic       sda_oe_out,
  input wire logic       serial_irq_out
);
  logic [7:0] own_reg;
  logic [5:0] per_reg;
  logic       on_reg;
  logic       ien_reg;
  logic       dat_acc;

  // Software touch of the data buffer ends a stretch
  assign dat_acc = (reg_rd_in | reg_wr_in) && reg_addr_in == 8'h00;

  // Shadows of software settings; a time-out must leave them alone
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      own_reg <= 8'h00;
      per_reg <= 6'h00;
      on_reg  <= 1'b0;
      ien_reg <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 8'h01) own_reg <= reg_wdata_in;
      if (reg_addr_in == 8'h04) per_reg <= reg_wdata_in[5:0];
      if (reg_addr_in == 8'h02) begin
        on_reg <= reg_wdata_in[7:5] == 3'h6 && reg_wdata_in[1];
      end
      if (reg_addr_in == 8'h05) ien_reg <= reg_wdata_in[0];
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  property p_drv_zero;
    scl_drv_out == 1'b0 && sda_drv_out == 1'b0;
  endproperty
  a_drv_zero: assert property (p_drv_zero)
    else $error("open-drain value not low");
  property p_irq_pulse;
    serial_irq_out |=> !serial_irq_out;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt longer than one cycle");
  property p_irq_en;
    serial_irq_out |-> ien_reg;
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("interrupt while disabled");
  property p_release;
    dat_acc && scl_oe_out |=> !scl_oe_out;
  endproperty
  a_release: assert property (p_release)
    else $error("clock held after buffer access");
  property p_stretch_low;
    $rose(scl_oe_out) |-> !scl_in;
  endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("stretch begun while clock high");
  property p_sda_low;
    $rose(sda_oe_out) |-> !scl_in;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data pulled while clock high");
  property p_oe_on;
    scl_oe_out || sda_oe_out |-> on_reg || $past(on_reg);
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("pins driven while interface off");
  property p_rd_own;
    reg_rd_in && reg_addr_in == 8'h01 |=> reg_rdata_out == own_reg;
  endproperty
  a_rd_own: assert property (p_rd_own)
    else $error("own address readback wrong");
  property p_rd_per;
    reg_rd_in && reg_addr_in == 8'h04 |=> reg_rdata_out[5:0] == per_reg;
  endproperty
  a_rd_per: assert property (p_rd_per)
    else $error("period field readback wrong");
  property p_rd_idle;
    !reg_rd_in || reg_addr_in > 8'h05 |=> reg_rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero");
endmodule : ist_i2c_slave_sva

bind ist_i2c_slave ist_i2c_slave_sva u_sva (
  .clk_sys_in     (clk_sys_in),
  .nrst_in        (nrst_in),
  .reg_addr_in    (reg_addr_in),
  .reg_wdata_in   (reg_wdata_in),
  .reg_wr_in      (reg_wr_in),
  .reg_rd_in      (reg_rd_in),
  .reg_rdata_out  (reg_rdata_out),
  .scl_in         (scl_in),
  .scl_drv_out    (scl_drv_out),
  .scl_oe_out     (scl_oe_out),
  .sda_drv_out    (sda_drv_out),
  .sda_oe_out     (sda_oe_out),
  .serial_irq_out (serial_irq_out)
);

// ==== verification/ist_i2c_master_model.sv ====
// Behavioural I2C bus master on the far side of the slave
`timescale 1ns/1ps
module ist_i2c_master_model (
  // Wire levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Pull-down enables
  output logic      scl_oe_out,
  output logic      sda_oe_out
);
  int hang_count;

  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
    hang_count = 0;
  end

  // Release SCL; a stretching slave may hold it, so the wait is bounded
  task automatic scl_high();
    int n;
    scl_oe_out = 1'b0;
    n = 0;
    while (scl_in !== 1'b1 && n < 5000) begin
      #40;
      n++;
    end
    if (n == 5000) hang_count++;
    #160;
  endtask : scl_high

  // SDA moves only with SCL low and is sampled late in the high phase
  task automatic bit_cycle(input logic b, output logic s);
    #80 sda_oe_out = ~b;
    #160;
    scl_high();
    s = sda_in;
    scl_oe_out = 1'b1;
    #160;
  endtask : bit_cycle

  task automatic start();
    sda_oe_out = 1'b1;
    #160 scl_oe_out = 1'b1;
    #160;
  endtask : start

  task automatic stop();
    #80 sda_oe_out = 1'b1;
    #160;
    scl_high();
    sda_oe_out = 1'b0;
    #320;
  endtask : stop

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
    bit_cycle(1'b1, ack);
  endtask : send_byte

  task automatic recv_byte(input logic ack_in, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
    bit_cycle(ack_in, s);
  endtask : recv_byte
endmodule : ist_i2c_master_model

// ==== verification/ist_i2c_slave_bench.sv ====
// Self-checking bench for the I2C slave with time-out
`timescale 1ns/1ps
module ist_i2c_slave_bench;
  logic       clk_sys_in;
  logic       nrst_in;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       scl_oe;
  logic       sda_oe;
  logic       m_scl_oe;
  logic       m_sda_oe;
  logic       slow_clk;
  logic       irq;
  logic [7:0] st;
  logic [7:0] d;
  logic       ack;
  wire        scl;
  wire        sda;
  int         bad_count;
  int         comparisons;
  int         irq_count;
  int         n0;
  int         c;
  logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'hE0, 8'h81, 8'h00, 8'h00,
                              8'h00};

  // Pull-ups: a wire is low while any party enables its pull-down
  assign scl = ~(scl_oe | m_scl_oe);
  assign sda = ~(sda_oe | m_sda_oe);

  ist_i2c_slave #(.TO_PRESCALE(4)) dut (
    .clk_sys_in         (clk_sys_in),
    .nrst_in            (nrst_in),
    .reg_addr_in        (reg_addr),
    .reg_wdata_in       (reg_wdata),
    .reg_wr_in          (reg_wr),
    .reg_rd_in          (reg_rd),
    .reg_rdata_out      (reg_rdata),
    .scl_in             (scl),
    .scl_drv_out        (),
    .scl_oe_out         (scl_oe),
    .sda_in             (sda),
    .sda_drv_out        (),
    .sda_oe_out         (sda_oe),
    .low_speed_clock_in (slow_clk),
    .serial_irq_out     (irq)
  );

  ist_i2c_master_model m (
    .scl_in     (scl),
    .sda_in     (sda),
    .scl_oe_out (m_scl_oe),
    .sda_oe_out (m_sda_oe)
  );

  // Clocks: 40 ns system, 400 ns low-speed, unrelated phase
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    slow_clk = 1'b0;
    #7;
    forever #200 slow_clk = ~slow_clk;
  end

  // Interrupt pulses are counted so no single pulse can be missed
  always @(posedge clk_sys_in) begin
    if (irq === 1'b1) irq_count <= irq_count + 1;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys_in);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_in);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys_in);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rchk

  task automatic wait_irq(input int lim, output int n);
    int base;
    base = irq_count;
    n = 0;
    while (irq_count == base && n < lim) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n == lim) begin
      bad_count++;
      finish_test();
    end
  endtask : wait_irq

  initial begin
    #2000000;
    bad_count++;
    finish_test();
  end

  initial begin
    nrst_in = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bad_count = 0;
    comparisons = 0;
    irq_count = 0;
    repeat (16) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 7; i++) rchk(8'(i), rst_tab[i]);
    $display("test reset values done");
    wr(8'h02, 8'hC2);
    wr(8'h01, 8'hA0);
    wr(8'h05, 8'h01);
    // Master writes two bytes; the second is refused by the slave
    n0 = irq_count;
    m.start();
    m.send_byte(8'hA0, ack);
    chk(ack, 8'h00);
    chk(8'(irq_count - n0), 8'h01);
    repeat (8) @(posedge clk_sys_in);
    chk(scl_oe, 8'h01);
    rd(8'h03, st);
    chk({st[6], st[5], st[2]}, 8'h06);
    wr(8'h03, 8'h00);
    rchk(8'h00, 8'hA0);
    @(posedge clk_sys_in);
    #1 chk(scl_oe, 8'h00);
    n0 = irq_count;
    m.send_byte(8'h35, ack);
    chk(ack, 8'h00);
    chk(8'(irq_count - n0), 8'h01);
    rd(8'h03, st);
    chk(st[7], 8'h01);
    wr(8'h03, 8'h08);
    rchk(8'h00, 8'h35);
    m.send_byte(8'h8E, ack);
    chk(ack, 8'h01);
    rchk(8'h00, 8'h8E);
    m.stop();
    rd(8'h03, st);
    chk(st[5], 8'h00);
    $display("test master write done");
    // A foreign address is neither acknowledged nor stretched
    n0 = irq_count;
    m.start();
    m.send_byte(8'h42, ack);
    chk(ack, 8'h01);
    chk(8'(irq_count - n0), 8'h00);
    chk(scl_oe, 8'h00);
    m.stop();
    $display("test foreign address done");
    // Master reads two bytes and refuses the second
    m.start();
    m.send_byte(8'hA1, ack);
    chk(ack, 8'h00);
    rd(8'h03, st);
    chk(st[2], 8'h01);
    wr(8'h03, 8'h10);
    wr(8'h00, 8'hB4);
    m.recv_byte(1'b0, d);
    chk(d, 8'hB4);
    rd(8'h03, st);
    chk({st[7], st[0]}, 8'h02);
    wr(8'h00, 8'h81);
    m.recv_byte(1'b1, d);
    chk(d, 8'h81);
    rd(8'h03, st);
    chk(st[0], 8'h01);
    repeat (8) @(posedge clk_sys_in);
    chk({scl_oe, sda_oe}, 8'h00);
    m.stop();
    $display("test master read done");
    // Stretch left standing until the bus times out
    wr(8'h04, 8'h81);
    m.start();
    m.send_byte(8'hA0, ack);
    wait_irq(400, c);
    chk({7'h00, c >= 60 && c <= 90}, 8'h01);
    rchk(8'h04, 8'h41);
    rchk(8'h03, 8'h81);
    rchk(8'h01, 8'hA0);
    rchk(8'h02, 8'hC2);
    chk({scl_oe, sda_oe}, 8'h00);
    wr(8'h04, 8'h41);
    rchk(8'h04, 8'h41);
    wr(8'h04, 8'h01);
    rchk(8'h04, 8'h01);
    m.stop();
    chk(8'(m.hang_count), 8'h00);
    $display("test time-out done");
    finish_test();
  end
endmodule : ist_i2c_slave_bench
